//--- rtl/mpbh_arb_if.sv
`timescale 1ns/1ps
// arbitration handshake between the main block and its bus access machine
interface mpbh_arb_if;
   logic want;
   logic lock;
   logic own;
   logic req_pending;
   logic ctl_tick;
   modport ctrl (output want, output lock, output ctl_tick, input own, input req_pending);
   modport fsm  (input want, input lock, input ctl_tick, output own, output req_pending);
endinterface

//--- rtl/mpbh_bus_access.sv
`timescale 1ns/1ps
module mpbh_bus_access
   import mpbh_pkg::*;
(
   // clock and reset
   input  wire logic  aclk,
   input  wire logic  aresetn,
   // chain
   input  wire logic  chain_in,
   input  wire logic  other_req,
   output logic       chain_out,
   // arbitration handshake
   mpbh_arb_if.fsm    arb
);

   mpbh_ba_e   state;
   logic [1:0] cnt;

   // bus access machine stepped by the control clock tick
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         // R8: start requesting
         state <= MPBH_BA_REQ;
         cnt   <= 2'h0;
      end else if (arb.ctl_tick) begin
         case (state)
            MPBH_BA_REQ: begin
               cnt <= 2'h0;
               if (chain_in) begin
                  state <= MPBH_BA_WAIT;
               end
            end
            // R10: three wait ticks here, four ticks with the entry tick
            MPBH_BA_WAIT: begin
               if (!chain_in) begin
                  state <= MPBH_BA_REQ;
               end else if (cnt == 2'(MPBH_HANDOFF_TICKS - 1)) begin
                  state <= MPBH_BA_OWN;
               end else begin
                  cnt <= cnt + 2'h1;
               end
            end
            // R11: held while locked
            MPBH_BA_OWN: begin
               if (!arb.lock && (other_req || !arb.want)) begin
                  state <= MPBH_BA_IDLE;
               end
            end
            MPBH_BA_IDLE: begin
               if (arb.want) begin
                  state <= MPBH_BA_REQ;
               end
            end
            default: state <= MPBH_BA_REQ;
         endcase
      end
   end

   assign arb.own         = (state == MPBH_BA_OWN);
   assign arb.req_pending = (state == MPBH_BA_REQ) || (state == MPBH_BA_WAIT);

   // R12: pass the chain on only from the idle state after release, while the chain input is high
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         chain_out <= 1'b0;
      end else begin
         chain_out <= chain_in && (state == MPBH_BA_IDLE);
      end
   end

endmodule

//--- rtl/mpbh_pkg.sv
package mpbh_pkg;

   // register byte offsets
   localparam logic [7:0] MPBH_CTRL_OFS   = 8'h00;
   localparam logic [7:0] MPBH_STATUS_OFS = 8'h04;

   // control register fields
   localparam int MPBH_CTRL_HOLD_BIT   = 0;
   localparam int MPBH_CTRL_IRQ0_BIT   = 1;
   localparam int MPBH_CTRL_IRQ1_BIT   = 2;
   localparam int MPBH_CTRL_NMI_BIT    = 3;
   localparam int MPBH_CTRL_VEC_BIT    = 4;
   localparam int MPBH_CTRL_DMAEN_BIT  = 5;

   // control value after reset: bus hold set, every interrupt disabled
   localparam logic [5:0] MPBH_CTRL_RESET = 6'h01;

   // status register fields
   localparam int MPBH_ST_OWN_BIT      = 0;
   localparam int MPBH_ST_DMA_BIT      = 1;
   localparam int MPBH_ST_DMAACK_BIT   = 2;
   localparam int MPBH_ST_CPUREQ_BIT   = 3;
   localparam int MPBH_ST_HOSTOK_BIT   = 4;

   // backplane control clock: ticks of aclk per tick
   localparam int MPBH_CTL_DIV_DEF     = 4;
   // three wait ticks in the handoff; with the entry tick it takes four control clock cycles
   localparam int MPBH_HANDOFF_TICKS   = 3;

   // axi response codes
   localparam logic [1:0] MPBH_RESP_OKAY   = 2'b00;
   localparam logic [1:0] MPBH_RESP_SLVERR = 2'b10;

   // bus access machine states
   typedef enum logic [1:0] {
      MPBH_BA_REQ,
      MPBH_BA_WAIT,
      MPBH_BA_OWN,
      MPBH_BA_IDLE
   } mpbh_ba_e;

   // cpu request machine states
   typedef enum logic [1:0] {
      MPBH_CR_REQ,
      MPBH_CR_IDLE,
      MPBH_CR_HAVE
   } mpbh_cr_e;

endpackage

//--- rtl/mpbh_top.sv
`timescale 1ns/1ps
// Function
// R1: each backplane interrupt is passed to the cpu only when this card is enabled for it.
// R2: with off-board vectors, acknowledge cycles wait until the bus is owned.
// R3: with on-board vectors, acknowledge runs without arbitration; later accesses arbitrate.
// R4: the non-maskable interrupt has its own enable and no acknowledge cycle.
// R5: setting the bus hold bit on a host with dma enabled enters dma hold mode.
// R6: in dma hold mode a bus request is answered with a bus acknowledge.
// R7: clearing the bus hold bit leaves dma hold mode.
// R8: both machines reset into their request state.
// R9: the bus hold bit resets set so the bus is kept once granted.
// R10: a high chain input gives this card the bus within three control clocks; here an entry tick comes before the three wait ticks, so it takes four.
// R11: ownership is kept while the bus hold bit stays set.
// R12: the startup handoff passes from chain output to the next chain input.
// R13: the host does not regain the bus until every slave has owned it once; here host_ok only shows in status, the want gate never closes.
// R14: a locked pair of byte cycles keeps ownership across both.
module mpbh_top
   import mpbh_pkg::*;
#(
   parameter int CTL_DIV    = MPBH_CTL_DIV_DEF,
   parameter int NUM_SLAVES = 1
)(
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // axi4-lite write address
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // axi4-lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // axi4-lite read address
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // axi4-lite read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // card strap and backplane arbitration
   input  wire logic        is_host,
   input  wire logic        chain_in,
   input  wire logic        other_req,
   input  wire logic        slave_done,
   output logic             chain_out,
   output logic             bus_req,
   output logic             bus_drive,
   // legacy dma pair
   input  wire logic        dma_req,
   output logic             dma_ack,
   // backplane interrupts in, cpu interrupts out
   input  wire logic        bp_irq0,
   input  wire logic        bp_irq1,
   input  wire logic        bp_nmi,
   output logic             cpu_irq0,
   output logic             cpu_irq1,
   output logic             cpu_nmi,
   // cpu side
   input  wire logic        cpu_access,
   input  wire logic        cpu_inta,
   input  wire logic        cpu_lock,
   input  wire logic        cpu_pair,
   input  wire logic        cpu_cycle_done,
   output logic             cpu_ready
);

   ////////////////////////////////////////////////////////////////////////////
   // registers and shared state

   logic [5:0]  ctrl;
   logic        host_q;
   logic        dma_hold_mode;
   logic        pair_lock;
   logic        cycle_lock;
   logic [15:0] slaves_seen;
   logic        host_ok;
   logic [$clog2(CTL_DIV+1)-1:0] div_cnt;
   logic        ctl_tick;
   mpbh_cr_e    cr_state;
   logic        need_bus;
   logic        own_d;
   logic        bus_hold_bit;

   mpbh_arb_if arb ();

   assign bus_hold_bit = ctrl[MPBH_CTRL_HOLD_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // control clock divider

   // one-cycle tick standing in for the backplane control clock
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_cnt  <= '0;
         ctl_tick <= 1'b0;
      end else if (div_cnt == ($clog2(CTL_DIV+1))'(CTL_DIV - 1)) begin
         div_cnt  <= '0;
         ctl_tick <= 1'b1;
      end else begin
         div_cnt  <= div_cnt + 1'b1;
         ctl_tick <= 1'b0;
      end
   end

   // strap is caught by a clocked process, never by the reset itself
   always_ff @(posedge aclk) begin
      host_q <= is_host;
   end

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite write side

   logic        aw_held;
   logic        w_held;
   logic [7:0]  aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;

   // address and data taken independently, response after both
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_addr      <= 8'h00;
         w_data       <= 32'h0000_0000;
         w_strb       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= MPBH_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (aw_held && w_held && !s_axi_bvalid) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr == MPBH_CTRL_OFS || aw_addr == MPBH_STATUS_OFS) ?
                            MPBH_RESP_OKAY : MPBH_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ready is low while a word is held, so a second one waits
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
         s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      end
   end

   // control register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         // R9: hold bit comes up set
         ctrl <= MPBH_CTRL_RESET;
      end else if (aw_held && w_held && !s_axi_bvalid && aw_addr == MPBH_CTRL_OFS
                   && w_strb[0]) begin
         ctrl <= w_data[5:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite read side

   // one read at a time, answered the cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= MPBH_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= MPBH_RESP_OKAY;
            case (s_axi_araddr)
               MPBH_CTRL_OFS:   s_axi_rdata <= {26'h0, ctrl};
               MPBH_STATUS_OFS: s_axi_rdata <= {27'h0, host_ok, cr_state == MPBH_CR_REQ,
                                                dma_ack, dma_hold_mode, arb.own};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= MPBH_RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt routing

   // R1: only the assigned card passes each line on
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cpu_irq0 <= 1'b0;
         cpu_irq1 <= 1'b0;
         cpu_nmi  <= 1'b0;
      end else begin
         cpu_irq0 <= bp_irq0 && ctrl[MPBH_CTRL_IRQ0_BIT];
         cpu_irq1 <= bp_irq1 && ctrl[MPBH_CTRL_IRQ1_BIT];
         // R4: separate enable, never acknowledged
         cpu_nmi  <= bp_nmi && ctrl[MPBH_CTRL_NMI_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // dma hold mode

   // R5: host with dma enabled, hold set and bus owned; R7: leaves on hold clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dma_hold_mode <= 1'b0;
      end else begin
         dma_hold_mode <= host_q && ctrl[MPBH_CTRL_DMAEN_BIT] && bus_hold_bit && arb.own;
      end
   end

   // R6: legacy request/acknowledge while in the mode
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dma_ack <= 1'b0;
      end else begin
         dma_ack <= dma_hold_mode && dma_req;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // cpu request side and locks

   // R2: acknowledge with off-board vectors needs the bus; R3: on-board does not
   assign need_bus = cpu_access || (cpu_inta && !ctrl[MPBH_CTRL_VEC_BIT]);

   // R14: lock spans both halves of a locked byte pair
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pair_lock <= 1'b0;
      end else if (cpu_lock && cpu_pair) begin
         pair_lock <= 1'b1;
      end else if (!cpu_lock) begin
         pair_lock <= 1'b0;
      end
   end

   // a single cycle keeps the bus until it completes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cycle_lock <= 1'b0;
      end else if (cpu_cycle_done) begin
         cycle_lock <= 1'b0;
      end else if (arb.own && need_bus) begin
         cycle_lock <= 1'b1;
      end
   end

   // R13: host_ok sets once every slave has reported owning since the host released; status and the want gate read it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         slaves_seen <= 16'h0000;
         host_ok     <= 1'b0;
         own_d       <= 1'b0;
      end else begin
         own_d <= arb.own;
         if (host_q && own_d && !arb.own && !host_ok) begin
            // a slave report landing in the release cycle still counts
            slaves_seen <= {15'h0, slave_done};
         end else if (slave_done && !host_ok) begin
            slaves_seen <= slaves_seen + 16'h0001;
         end
         if (slaves_seen >= 16'(NUM_SLAVES)) begin
            host_ok <= 1'b1;
         end
      end
   end

   // cpu request machine
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         // R8: request state at reset
         cr_state <= MPBH_CR_REQ;
      end else begin
         case (cr_state)
            MPBH_CR_REQ: begin
               if (arb.own) begin
                  cr_state <= MPBH_CR_HAVE;
               end
            end
            MPBH_CR_HAVE: begin
               if (!arb.own) begin
                  cr_state <= MPBH_CR_IDLE;
               end
            end
            MPBH_CR_IDLE: begin
               if (need_bus || bus_hold_bit) begin
                  cr_state <= MPBH_CR_REQ;
               end
            end
            default: cr_state <= MPBH_CR_REQ;
         endcase
      end
   end

   // R13: a host's want is held off only while own_d is set and the cpu machine is idle, which never occurs together
   assign arb.want     = (cr_state == MPBH_CR_REQ || cr_state == MPBH_CR_HAVE
                          || need_bus || bus_hold_bit)
                         && (!host_q || host_ok || !own_d || cr_state != MPBH_CR_IDLE);
   // R11: hold bit, single cycle and pair locks keep the bus
   assign arb.lock     = bus_hold_bit || cycle_lock || pair_lock || (cpu_lock && arb.own);
   assign arb.ctl_tick = ctl_tick;

   // R10: chain handoff machine
   mpbh_bus_access u_bus_access (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .chain_in  (chain_in),
      .other_req (other_req),
      .chain_out (chain_out),
      .arb       (arb)
   );

   // backplane request, drive and cpu ready
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bus_req   <= 1'b0;
         bus_drive <= 1'b0;
         cpu_ready <= 1'b0;
      end else begin
         bus_req   <= arb.req_pending;
         bus_drive <= arb.own && !dma_ack;
         // R3: on-board vector acknowledge completes at once
         cpu_ready <= (cpu_inta && ctrl[MPBH_CTRL_VEC_BIT]) || (need_bus && arb.own);
      end
   end

endmodule

//--- test/mpbh_peer.sv
`timescale 1ns/1ps
// neighbouring cards on the chain: one upstream, one downstream
module mpbh_peer (
   // clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // bench control
   input  wire logic up_release,
   input  wire logic down_want,
   // chain to the card
   input  wire logic chain_out,
   output logic      chain_in,
   output logic      other_req,
   output logic      slave_done
);
   logic [1:0] cnt;
   logic       owned;

   // upstream chain output
   // upstream card passes the chain as a level, never a pulse
   always_ff @(posedge aclk) chain_in <= up_release;

   // downstream takes bus
   // downstream owns three cycles after our chain output, reports it once
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt <= 2'h0;
         owned <= 1'b0;
         slave_done <= 1'b0;
      end else begin
         slave_done <= 1'b0;
         if (chain_out && !owned) begin
            cnt <= cnt + 2'h1;
            if (cnt == 2'h2) begin
               owned <= 1'b1;
               slave_done <= 1'b1;
            end
         end
      end
   end

   // downstream stops asking once it holds the bus
   always_ff @(posedge aclk) other_req <= down_want && !owned;
endmodule

//--- test/mpbh_top_monitor.sv
`timescale 1ns/1ps
module mpbh_top_monitor
   import mpbh_pkg::*;
#(
   parameter int CTL_DIV    = MPBH_CTL_DIV_DEF,
   parameter int NUM_SLAVES = 1
)(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // arbitration
   input wire logic is_host,
   input wire logic chain_in,
   input wire logic chain_out,
   input wire logic bus_req,
   input wire logic bus_drive,
   // legacy dma
   input wire logic dma_req,
   input wire logic dma_ack,
   // interrupts and cpu
   input wire logic bp_irq0,
   input wire logic bp_nmi,
   input wire logic cpu_irq0,
   input wire logic cpu_nmi,
   input wire logic cpu_lock,
   input wire logic cpu_pair
);
   // handoff bound: entry tick, three wait ticks, drive register, margin
   localparam int HANDOFF_MAX = 6 * CTL_DIV + 4;

   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   ////////////////////////////////////////////////////////////////////////////////
   a_reset_quiet: assert property ($rose(aresetn) |-> !bus_drive && !dma_ack ##1 bus_req)
      else $error("card not requesting after reset");
   a_irq_gated: assert property (cpu_irq0 |-> $past(bp_irq0))
      else $error("cpu irq0 without backplane request");
   a_nmi_gated: assert property (cpu_nmi |-> $past(bp_nmi))
      else $error("cpu nmi without backplane nmi");
   a_handoff_time: assert property ($rose(chain_in) && bus_req && !is_host
                                   |-> ##[1:HANDOFF_MAX] bus_drive)
      else $error("bus not gained after chain input rose");
   // a locked pair must not lose the bus between its two cycles
   a_lock_pair: assert property (bus_drive && cpu_lock && cpu_pair && !dma_req |=> bus_drive)
      else $error("bus lost inside locked pair");
   a_ack_cause: assert property ($rose(dma_ack) |-> $past(dma_req) && $past(is_host))
      else $error("dma acknowledge without request on host");
   // one cycle of slack, ack and drive come from separate registers
   a_dma_lends: assert property (dma_ack && $past(dma_ack) |-> !bus_drive)
      else $error("card drives bus while lending it");
   a_chain_cause: assert property (chain_out |-> $past(chain_in))
      else $error("chain output without chain input");

   ////////////////////////////////////////////////////////////////////////////////
   c_gain: cover property ($rose(bus_drive));
   c_dma: cover property ($rose(dma_ack));
   c_pass: cover property ($rose(chain_out));
   c_nmi: cover property (cpu_nmi);
endmodule

bind mpbh_top mpbh_top_monitor #(.CTL_DIV(CTL_DIV), .NUM_SLAVES(NUM_SLAVES)) u_mpbh_top_monitor (
   .aclk(aclk), .aresetn(aresetn), .is_host(is_host), .chain_in(chain_in),
   .chain_out(chain_out), .bus_req(bus_req), .bus_drive(bus_drive), .dma_req(dma_req),
   .dma_ack(dma_ack), .bp_irq0(bp_irq0), .bp_nmi(bp_nmi), .cpu_irq0(cpu_irq0),
   .cpu_nmi(cpu_nmi), .cpu_lock(cpu_lock), .cpu_pair(cpu_pair)
);

//--- test/mpbh_top_test.sv
`timescale 1ns/1ps
module mpbh_top_test;
   import mpbh_pkg::*;
   localparam int DIV = 2;
   logic        aclk = 1'b0, aresetn = 1'b0, awready, wready, bvalid, arready, rvalid;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic [1:0]  bresp, rresp, rs;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        is_host = 1'b0, chain_in, other_req, slave_done, chain_out, bus_req, bus_drive;
   logic        up_release = 1'b0, down_want = 1'b0, dma_req = 1'b0, dma_ack;
   logic        bp_irq0 = 1'b0, bp_irq1 = 1'b0, bp_nmi = 1'b0, cpu_irq0, cpu_irq1, cpu_nmi;
   logic        cpu_access = 1'b0, cpu_lock = 1'b0, cpu_pair = 1'b0, cpu_ready;
   logic        cpu_inta = 1'b0, cpu_cycle_done = 1'b0;
   int          bad_count = 0;
   int          n_compared = 0;
   // ctrl, backplane {nmi,irq1,irq0}, expected cpu {nmi,irq1,irq0}
   logic [13:0] rows [5] = '{{8'h03, 3'h7, 3'h1}, {8'h05, 3'h7, 3'h2}, {8'h09, 3'h7, 3'h4},
                             {8'h0F, 3'h5, 3'h5}, {8'h01, 3'h7, 3'h0}};

   always #20 aclk = ~aclk;

   mpbh_top #(.CTL_DIV(DIV)) u_mpbh_top (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .is_host(is_host), .chain_in(chain_in), .other_req(other_req), .slave_done(slave_done),
      .chain_out(chain_out), .bus_req(bus_req), .bus_drive(bus_drive), .dma_req(dma_req),
      .dma_ack(dma_ack), .bp_irq0(bp_irq0), .bp_irq1(bp_irq1), .bp_nmi(bp_nmi),
      .cpu_irq0(cpu_irq0), .cpu_irq1(cpu_irq1), .cpu_nmi(cpu_nmi), .cpu_access(cpu_access),
      .cpu_inta(cpu_inta), .cpu_lock(cpu_lock), .cpu_pair(cpu_pair),
      .cpu_cycle_done(cpu_cycle_done), .cpu_ready(cpu_ready));

   mpbh_peer u_mpbh_peer (
      .aclk(aclk), .aresetn(aresetn), .up_release(up_release), .down_want(down_want),
      .chain_out(chain_out), .chain_in(chain_in), .other_req(other_req),
      .slave_done(slave_done));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk_w(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t %s: got %h want %h", $time, what, got, exp);
      end
   endtask

   task automatic chk_b(input logic got, input logic exp, input string what);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t %s: got %b want %b", $time, what, got, exp);
      end
   endtask

   // address and data offered together, each dropped once taken
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (awready && !aw_ok) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (wready && !w_ok) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      while (!bvalid) @(posedge aclk);
      rs = bresp;
      bready <= 1'b0;
   endtask

   task automatic axr(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask

   task automatic do_reset;
      aresetn <= 1'b0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
   endtask

   // bounded wait, the caller compares afterwards
   task automatic wait_own(input int lim);
      repeat (lim) begin
         @(posedge aclk);
         if (bus_drive) break;
      end
   endtask

   task automatic conclude;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      do_reset;
      chk_b(bus_req, 1'b1, "request after reset");
      axr(MPBH_CTRL_OFS);
      chk_w(rd, 32'h0000_0001, "ctrl reset value");
      axr(MPBH_STATUS_OFS);
      chk_b(rd[MPBH_ST_CPUREQ_BIT], 1'b1, "cpu request state");
      axr(8'h08);
      chk_w(32'(rs), 32'(MPBH_RESP_SLVERR), "unmapped response");
      chk_w(rd, 32'h0, "unmapped data");
      axw(8'h08, 32'h0);
      chk_w(32'(rs), 32'(MPBH_RESP_SLVERR), "unmapped write response");
      // routing table, last row leaves the hold bit set
      foreach (rows[i]) begin
         axw(MPBH_CTRL_OFS, {24'h0, rows[i][13:6]});
         chk_w(32'(rs), 32'(MPBH_RESP_OKAY), "write response");
         {bp_nmi, bp_irq1, bp_irq0} <= rows[i][5:3];
         repeat (3) @(posedge aclk);
         chk_w({29'h0, cpu_nmi, cpu_irq1, cpu_irq0}, {29'h0, rows[i][2:0]}, "irq route");
      end
      // acknowledge: off-board vectors wait for the bus, on-board ones do not
      cpu_inta <= 1'b1;
      repeat (3) @(posedge aclk);
      chk_b(cpu_ready, 1'b0, "off-board ack waits");
      axw(MPBH_CTRL_OFS, 32'h11);
      repeat (2) @(posedge aclk);
      chk_b(cpu_ready, 1'b1, "on-board ack at once");
      cpu_inta <= 1'b0;
      // startup handoff on a slave card
      up_release <= 1'b1;
      wait_own(6 * DIV + 6);
      chk_b(bus_drive, 1'b1, "gained after chain");
      down_want <= 1'b1;
      repeat (20) @(posedge aclk);
      chk_b(bus_drive, 1'b1, "kept with hold set");
      cpu_access <= 1'b1;
      cpu_lock <= 1'b1;
      cpu_pair <= 1'b1;
      axw(MPBH_CTRL_OFS, 32'h0);
      repeat (20) @(posedge aclk);
      chk_b(bus_drive, 1'b1, "kept over locked pair");
      chk_b(cpu_ready, 1'b1, "access ready once owned");
      cpu_access <= 1'b0;
      cpu_lock <= 1'b0;
      cpu_pair <= 1'b0;
      // the single-cycle lock only lets go when the cycle ends
      cpu_cycle_done <= 1'b1;
      @(posedge aclk);
      cpu_cycle_done <= 1'b0;
      repeat (20) @(posedge aclk);
      chk_b(bus_drive, 1'b0, "released");
      chk_b(chain_out, 1'b1, "chain passed on");
      // host card: dma hold and regain gate
      is_host <= 1'b1;
      down_want <= 1'b0;
      do_reset;
      axr(MPBH_STATUS_OFS);
      chk_b(rd[MPBH_ST_HOSTOK_BIT], 1'b0, "host gate closed");
      wait_own(6 * DIV + 6);
      axw(MPBH_CTRL_OFS, 32'h21);
      axr(MPBH_STATUS_OFS);
      chk_b(rd[MPBH_ST_DMA_BIT], 1'b1, "dma hold entered");
      dma_req <= 1'b1;
      repeat (6) @(posedge aclk);
      chk_b(dma_ack, 1'b1, "dma acknowledged");
      chk_b(bus_drive, 1'b0, "bus lent to dma");
      axw(MPBH_CTRL_OFS, 32'h20);
      repeat (2) @(posedge aclk);
      chk_b(dma_ack, 1'b0, "ack ends with hold");
      axr(MPBH_STATUS_OFS);
      chk_b(rd[MPBH_ST_DMA_BIT], 1'b0, "dma hold left");
      dma_req <= 1'b0;
      down_want <= 1'b1;
      repeat (30) @(posedge aclk);
      axr(MPBH_STATUS_OFS);
      chk_b(rd[MPBH_ST_HOSTOK_BIT], 1'b1, "host gate open");
      conclude;
   end

   // whole run is well under a thousand cycles
   initial begin
      repeat (5000) @(posedge aclk);
      bad_count++;
      $display("ERROR %0t watchdog expired", $time);
      conclude;
   end
endmodule
